// >>> pkg/fdcsr_pkg.sv
// Constants, types and command layout for the sector read engine.
// Assumes one 200 MHz clock; the drive side delivers decoded fields as strobes.
// Functional notes
// - read, write and verify share parameter and result lists; low five bits differ.
// - implied seek when enabled, drive busy held high during that seek.
// - failed implied seek reported in results, cylinder holds failing cylinder.
// - load head if unloaded, settle, scan IDs, move matching data to FIFO.
// - after each sector, sector number plus one, keep reading.
// - terminal count or overrun stops delivery; sector finishes, CRC checked, then end.
// - sector size is 128 shifted left by the size code.
// - size code zero with length below 128 sends only that many bytes.
// - multi-track reads side 0 then side 1 of the same cylinder.
// - head stays loaded until unload time; early command skips settle.
// - two index pulses without the sector give code 01 and no-data flag.
// - CRC error gives code 01, data error; ID CRC also sets data-field error.
// - read data: deleted mark sets control mark; skip 0 stops, skip 1 skips.
// - read deleted data: same with normal and deleted marks swapped.
// - otherwise cylinder or sector advances automatically.
// - multi-track ends on side 1, doubling the capacity.
// - early end leaves C, H, N, sector plus one; final sector wraps to 01.
// - multi-track flag is bit 7, skip flag bit 5 of the opening byte.
package fdcsr_pkg;
   localparam int         CMD_BYTES      = 9;
   localparam int         RES_BYTES      = 7;
   localparam int         MT_BIT         = 7;
   localparam int         SK_BIT         = 5;
   localparam logic [4:0] OP_READ        = 5'h06;
   localparam logic [4:0] OP_READ_DEL    = 5'h0C;
   localparam logic [7:0] BASE_SECTOR    = 8'h01;
   localparam logic [7:0] SHORT_LIMIT    = 8'h80;
   localparam logic [1:0] IC_NORMAL      = 2'h0;
   localparam logic [1:0] IC_ABNORMAL    = 2'h1;
   localparam int         IC_POS         = 6;
   localparam int         SEEKEND_POS    = 5;
   localparam int         HEAD_POS       = 2;
   localparam int         DE_POS         = 5;
   localparam int         ND_POS         = 2;
   localparam int         CM_POS         = 6;
   localparam int         DD_POS         = 5;
   localparam int         INDEX_LIMIT    = 2;
   localparam int         CLK_MHZ        = 200;
   localparam int         STEP_UNIT_NS   = 1000;
   localparam int         STEP_UNIT_CYC  = STEP_UNIT_NS * CLK_MHZ / 1000;

   typedef enum logic [2:0] {
      FDCSR_IDLE   = 3'b000,
      FDCSR_PARAM  = 3'b001,
      FDCSR_SEEK   = 3'b010,
      FDCSR_SETTLE = 3'b011,
      FDCSR_SCAN   = 3'b100,
      FDCSR_DATA   = 3'b101,
      FDCSR_RESULT = 3'b110
   } fdcsr_state_e;

   typedef struct packed {
      logic [7:0] cyl;
      logic [7:0] head;
      logic [7:0] sector;
      logic [7:0] size;
   } fdcsr_chrn_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } fdcsr_byte_s;
endpackage

// >>> rtl/fdcsr_timer.sv
// Down counter for settle and unload intervals, in microsecond steps.
// Assumes the caller loads it only while it needs a fresh interval.
`timescale 1ns/1ps
module fdcsr_timer (
   input  wire logic       sys_clk,   // Clock
   input  wire logic       reset,     // Async reset
   input  wire logic       load,      // Start interval
   input  wire logic [7:0] units,     // Interval in microseconds
   output logic            done_q     // Interval elapsed, level
);
   logic [7:0]  units_q;
   logic [15:0] pre_q;

   // Prescaler gives one step per microsecond
   wire step = (pre_q == 16'(fdcsr_pkg::STEP_UNIT_CYC - 1));

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         units_q <= 8'h00;
         pre_q   <= 16'h0000;
         done_q  <= 1'b1;
      end else if (load) begin
         units_q <= units;
         pre_q   <= 16'h0000;
         done_q  <= (units == 8'h00);
      end else if (!done_q) begin
         pre_q <= step ? 16'h0000 : pre_q + 16'h0001;
         if (step) begin
            units_q <= units_q - 8'h01;
            done_q  <= (units_q == 8'h01);
         end
      end
   end
endmodule

// >>> rtl/fdcsr_engine.sv
// Read Data / Read Deleted Data execution engine.
// Assumes the drive front end delivers decoded ID fields, data bytes and CRC verdicts.
`timescale 1ns/1ps
module fdcsr_engine (
   input  wire logic                   sys_clk,         // Clock
   input  wire logic                   reset,           // Async reset
   input  wire logic                   cmd_valid,       // Command byte strobe
   input  wire logic [7:0]             cmd_byte,        // Command byte
   input  wire logic                   implied_seek_en, // Implied seek enabled
   input  wire logic [7:0]             settle_units,    // Settle time, us
   input  wire logic [7:0]             unload_units,    // Unload time, us
   input  wire logic                   seek_done,       // Seek finished, pulse
   input  wire logic                   seek_fail,       // Seek failed, with done
   input  wire logic [7:0]             seek_cyl,        // Cylinder at seek end
   input  wire logic                   index_pulse_input, // Index pulse, one cycle
   input  wire logic                   id_valid,        // ID field decoded, pulse
   input  wire fdcsr_pkg::fdcsr_chrn_s id_field,        // Decoded ID
   input  wire logic                   id_crc_ok,       // ID CRC good, with id_valid
   input  wire logic                   mark_valid,      // Data mark seen, pulse
   input  wire logic                   mark_deleted,    // Mark is deleted type
   input  wire logic                   disk_byte_valid, // Data byte from disk
   input  wire logic [7:0]             disk_byte,       // Data byte value
   input  wire logic                   data_end,        // Sector end, pulse
   input  wire logic                   data_crc_ok,     // Data CRC good, with end
   input  wire logic                   terminal_count,  // Host terminal count
   input  wire logic                   fifo_ready,      // FIFO can take a byte
   output fdcsr_pkg::fdcsr_byte_s      fifo_out_q,      // Byte to FIFO
   output logic                        fifo_over_q,     // Implied TC seen
   output logic                        drive_busy_q,    // Per-drive busy
   output logic                        seek_req_q,      // Seek request, level
   output logic                        head_load_q,     // Head loaded
   output logic                        exec_q,          // Execution phase
   output logic                        res_valid_q,     // Result byte valid
   output logic [7:0]                  res_byte_q       // Result byte
);
   // ==========================================================
   // Command capture
   fdcsr_pkg::fdcsr_state_e state_q;
   logic [7:0]  cmd_q [fdcsr_pkg::CMD_BYTES];
   logic [3:0]  cnt_q;
   logic [7:0]  st0_q, st1_q, st2_q;
   fdcsr_pkg::fdcsr_chrn_s addr_q;
   logic [1:0]  idx_q;
   logic        stop_q, cmstop_q, skipping_q, tc_q, settle_ld_q;
   logic [14:0] bcnt_q;
   logic        settle_done, unload_done;

   wire [4:0] opcode  = cmd_q[0][4:0];
   wire       deleted = (opcode == fdcsr_pkg::OP_READ_DEL);
   wire       mt      = cmd_q[0][fdcsr_pkg::MT_BIT];
   wire       sk      = cmd_q[0][fdcsr_pkg::SK_BIT];
   wire [7:0] final_sector_number     = cmd_q[6];
   wire [7:0] data_length_byte     = cmd_q[8];

   function automatic logic [14:0] sect_len(input logic [2:0] n);
      sect_len = 15'h0080 << n;
   endfunction

   // short transfer limit, length ignored when size nonzero
   wire [14:0] xfer_len = (addr_q.size == 8'h00 && data_length_byte < fdcsr_pkg::SHORT_LIMIT)
                        ? {7'h00, data_length_byte} : sect_len(addr_q.size[2:0]);
   wire        deliver  = !tc_q && !skipping_q && (bcnt_q < xfer_len);
   wire        match    = id_valid && id_field == addr_q;
   // control mark when mark type disagrees with command
   wire        off_mark = mark_deleted ^ deleted;
   wire        last_sec = (addr_q.sector == final_sector_number);
   wire        end_side = mt && !addr_q.head[0];
   wire        fifo_push = disk_byte_valid && deliver;
   wire        tc_event = terminal_count || (fifo_push && !fifo_ready);

   fdcsr_timer u_settle (
      .sys_clk (sys_clk),
      .reset   (reset),
      .load    (settle_ld_q),
      .units   (settle_units),
      .done_q  (settle_done)
   );

   fdcsr_timer u_unload (
      .sys_clk (sys_clk),
      .reset   (reset),
      .load    (state_q == fdcsr_pkg::FDCSR_RESULT),
      .units   (unload_units),
      .done_q  (unload_done)
   );

   // ==========================================================
   // Sequencer
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q      <= fdcsr_pkg::FDCSR_IDLE;
         cnt_q        <= 4'h0;
         st0_q        <= 8'h00;
         st1_q        <= 8'h00;
         st2_q        <= 8'h00;
         addr_q       <= '0;
         idx_q        <= 2'h0;
         stop_q       <= 1'b0;
         cmstop_q     <= 1'b0;
         skipping_q   <= 1'b0;
         tc_q         <= 1'b0;
         bcnt_q       <= 15'h0000;
         settle_ld_q  <= 1'b0;
         drive_busy_q <= 1'b0;
         seek_req_q   <= 1'b0;
         head_load_q  <= 1'b0;
         exec_q       <= 1'b0;
         res_valid_q  <= 1'b0;
         res_byte_q   <= 8'h00;
         fifo_out_q   <= '0;
         fifo_over_q  <= 1'b0;
         for (int i = 0; i < fdcsr_pkg::CMD_BYTES; i++) begin
            cmd_q[i] <= 8'h00;
         end
      end else begin
         settle_ld_q <= 1'b0;
         fifo_out_q  <= '0;
         res_valid_q <= 1'b0;
         if (state_q == fdcsr_pkg::FDCSR_IDLE && unload_done) begin
            head_load_q <= 1'b0;
         end
         unique case (state_q)
            fdcsr_pkg::FDCSR_IDLE: begin
               if (cmd_valid) begin
                  cmd_q[0] <= cmd_byte;
                  cnt_q    <= 4'h1;
                  state_q  <= fdcsr_pkg::FDCSR_PARAM;
               end
            end
            fdcsr_pkg::FDCSR_PARAM: begin
               if (cmd_valid) begin
                  cmd_q[cnt_q] <= cmd_byte;
                  cnt_q        <= cnt_q + 4'h1;
                  if (cnt_q == 4'(fdcsr_pkg::CMD_BYTES - 1)) begin
                     exec_q <= 1'b1;
                     st0_q  <= {5'h00, cmd_q[1][fdcsr_pkg::HEAD_POS:0]};
                     st1_q  <= 8'h00;
                     st2_q  <= 8'h00;
                     tc_q   <= 1'b0;
                     fifo_over_q <= 1'b0;
                     addr_q <= '{cyl: cmd_q[2], head: cmd_q[3], sector: cmd_q[4],
                                 size: cmd_q[5]};
                     if (implied_seek_en) begin
                        seek_req_q   <= 1'b1;
                        drive_busy_q <= 1'b1;
                        state_q      <= fdcsr_pkg::FDCSR_SEEK;
                     end else begin
                        state_q <= fdcsr_pkg::FDCSR_SETTLE;
                        settle_ld_q <= !head_load_q;
                     end
                  end
               end
            end
            fdcsr_pkg::FDCSR_SEEK: begin
               if (seek_done) begin
                  seek_req_q   <= 1'b0;
                  drive_busy_q <= 1'b0;
                  if (seek_fail) begin
                     st0_q[7:6]  <= fdcsr_pkg::IC_ABNORMAL;
                     st0_q[fdcsr_pkg::SEEKEND_POS] <= 1'b1;
                     addr_q.cyl  <= seek_cyl;
                     state_q     <= fdcsr_pkg::FDCSR_RESULT;
                     cnt_q       <= 4'h0;
                  end else begin
                     state_q     <= fdcsr_pkg::FDCSR_SETTLE;
                     settle_ld_q <= !head_load_q;
                  end
               end
            end
            fdcsr_pkg::FDCSR_SETTLE: begin
               // head load and settle; loaded head skips it
               head_load_q <= 1'b1;
               if (!settle_ld_q && settle_done) begin
                  idx_q   <= 2'h0;
                  state_q <= fdcsr_pkg::FDCSR_SCAN;
               end
            end
            fdcsr_pkg::FDCSR_SCAN: begin
               if (match && !id_crc_ok) begin
                  st0_q[7:6] <= fdcsr_pkg::IC_ABNORMAL;
                  st1_q[fdcsr_pkg::DE_POS] <= 1'b1;
                  st2_q[fdcsr_pkg::DD_POS] <= 1'b1;
                  state_q <= fdcsr_pkg::FDCSR_RESULT;
                  cnt_q   <= 4'h0;
               end else if (match) begin
                  bcnt_q     <= 15'h0000;
                  skipping_q <= 1'b0;
                  cmstop_q   <= 1'b0;
                  state_q    <= fdcsr_pkg::FDCSR_DATA;
               end else if (index_pulse_input) begin
                  idx_q <= idx_q + 2'h1;
                  if (idx_q == 2'(fdcsr_pkg::INDEX_LIMIT - 1)) begin
                     st0_q[7:6] <= fdcsr_pkg::IC_ABNORMAL;
                     st1_q[fdcsr_pkg::ND_POS] <= 1'b1;
                     state_q <= fdcsr_pkg::FDCSR_RESULT;
                     cnt_q   <= 4'h0;
                  end
               end
            end
            fdcsr_pkg::FDCSR_DATA: begin
               if (mark_valid && off_mark) begin
                  st2_q[fdcsr_pkg::CM_POS] <= 1'b1;
                  skipping_q <= sk;
                  cmstop_q   <= !sk;
               end
               if (tc_event) begin
                  tc_q <= 1'b1;
                  fifo_over_q <= !terminal_count;
               end
               if (fifo_push && fifo_ready) begin
                  fifo_out_q <= '{valid: 1'b1, data: disk_byte};
               end
               if (disk_byte_valid) begin
                  bcnt_q <= bcnt_q + 15'h0001;
               end
               if (data_end) begin
                  idx_q <= 2'h0;
                  if (!data_crc_ok && !skipping_q) begin
                     st0_q[7:6] <= fdcsr_pkg::IC_ABNORMAL;
                     st1_q[fdcsr_pkg::DE_POS] <= 1'b1;
                     state_q <= fdcsr_pkg::FDCSR_RESULT;
                     cnt_q   <= 4'h0;
                  end else if (cmstop_q) begin
                     state_q <= fdcsr_pkg::FDCSR_RESULT;
                     cnt_q   <= 4'h0;
                  end else begin
                     if (!last_sec) begin
                        addr_q.sector <= addr_q.sector + 8'h01;
                     end else begin
                        addr_q.sector <= fdcsr_pkg::BASE_SECTOR;
                        addr_q.head[0] <= mt ? ~addr_q.head[0] : addr_q.head[0];
                        if (!end_side) begin
                           addr_q.cyl <= addr_q.cyl + 8'h01;
                        end
                     end
                     if (tc_q || tc_event || (last_sec && !end_side)) begin
                        state_q <= fdcsr_pkg::FDCSR_RESULT;
                        cnt_q   <= 4'h0;
                     end else begin
                        state_q <= fdcsr_pkg::FDCSR_SCAN;
                     end
                  end
               end
            end
            fdcsr_pkg::FDCSR_RESULT: begin
               exec_q      <= 1'b0;
               res_valid_q <= 1'b1;
               unique case (cnt_q)
                  4'h0:    res_byte_q <= st0_q;
                  4'h1:    res_byte_q <= st1_q;
                  4'h2:    res_byte_q <= st2_q;
                  4'h3:    res_byte_q <= addr_q.cyl;
                  4'h4:    res_byte_q <= addr_q.head;
                  4'h5:    res_byte_q <= addr_q.sector;
                  default: res_byte_q <= addr_q.size;
               endcase
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == 4'(fdcsr_pkg::RES_BYTES - 1)) begin
                  state_q <= fdcsr_pkg::FDCSR_IDLE;
               end
            end
            default: state_q <= fdcsr_pkg::FDCSR_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Checks
   // busy tracks the seek
   a_busy_seek: assert property (@(posedge sys_clk) disable iff (reset)
      (state_q == fdcsr_pkg::FDCSR_SEEK) |-> drive_busy_q)
      else $error("busy low during seek");
   a_nd_index: assert property (@(posedge sys_clk) disable iff (reset)
      (state_q == fdcsr_pkg::FDCSR_SCAN && !match && index_pulse_input && idx_q == 2'h1)
      |=> st1_q[fdcsr_pkg::ND_POS] && state_q == fdcsr_pkg::FDCSR_RESULT)
      else $error("no-data not flagged");
   a_tc_quiet: assert property (@(posedge sys_clk) disable iff (reset)
      tc_q |=> !fifo_out_q.valid)
      else $error("byte after terminal count");
   a_res_len: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(res_valid_q) |-> res_valid_q [*7] ##1 !res_valid_q)
      else $error("result burst not seven bytes");
   // head stays loaded until unload timer done
   a_head_hold: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(head_load_q) |-> $past(unload_done))
      else $error("head unloaded early");
   // data CRC fault sets data error
   a_crc_err: assert property (@(posedge sys_clk) disable iff (reset)
      (state_q == fdcsr_pkg::FDCSR_DATA && data_end && !data_crc_ok && !skipping_q)
      |=> st1_q[fdcsr_pkg::DE_POS] && st0_q[7:6] == fdcsr_pkg::IC_ABNORMAL)
      else $error("CRC fault not flagged");
   a_short_len: assert property (@(posedge sys_clk) disable iff (reset)
      fifo_out_q.valid |-> bcnt_q <= xfer_len)
      else $error("too many bytes delivered");
   // control mark flagged on mismatched mark
   a_cm_flag: assert property (@(posedge sys_clk) disable iff (reset)
      (state_q == fdcsr_pkg::FDCSR_DATA && mark_valid && off_mark)
      |=> st2_q[fdcsr_pkg::CM_POS])
      else $error("control mark missing");
   c_result: cover property (@(posedge sys_clk) $rose(res_valid_q));
   c_skip: cover property (@(posedge sys_clk) skipping_q && data_end);
   c_tc: cover property (@(posedge sys_clk) $rose(tc_q));
endmodule

// >>> test/fdcsr_drive_model.sv
// Behavioural drive: answers seeks, spins four sectors a turn with an index pulse.
// Assumes size code zero sectors and that the engine reads only matching IDs.
`timescale 1ns/1ps
module fdcsr_drive_model (
   input  wire logic             sys_clk,           // Clock
   input  wire logic             exec_q,            // Engine executing
   input  wire logic             seek_req_q,        // Seek wanted
   input  wire logic [7:0]       cyl,               // Cylinder under head
   input  wire logic [3:0]       mode,              // Fail seek, no sector, bad CRC, deleted
   output logic                  seek_done,         // Seek end pulse
   output logic                  seek_fail,         // Seek failed
   output logic [7:0]            seek_cyl,          // Cylinder reached
   output logic                  index_pulse_input, // Index pulse
   output logic                  id_valid,          // ID strobe
   output fdcsr_pkg::fdcsr_chrn_s id_field,         // ID value
   output logic                  id_crc_ok,         // ID CRC verdict
   output logic                  mark_valid,        // Data mark strobe
   output logic                  mark_deleted,      // Deleted mark
   output logic                  disk_byte_valid,   // Data byte strobe
   output logic [7:0]            disk_byte,         // Data byte
   output logic                  data_end,          // Sector end
   output logic                  data_crc_ok        // Data CRC verdict
);
   int sec = 1;
   initial begin
      {seek_done, seek_fail, seek_cyl, index_pulse_input, id_valid, id_field, id_crc_ok} = '0;
      {mark_valid, mark_deleted, disk_byte_valid, disk_byte, data_end, data_crc_ok} = '0;
      forever begin
         @(posedge sys_clk);
         if (seek_req_q) begin
            repeat (20) @(posedge sys_clk);
            seek_done <= 1'b1;
            seek_fail <= mode[3];
            // failing seek reports the target cylinder with its low four bits inverted
            seek_cyl  <= cyl ^ 8'h0F;
            @(posedge sys_clk);
            seek_done <= 1'b0;
            repeat (4) @(posedge sys_clk);
         end else if (exec_q) begin
            index_pulse_input <= (sec == 1);
            id_valid  <= 1'b1;
            id_field  <= {cyl, 8'h00, 8'(mode[2] ? sec + 8 : sec), 8'h00};
            id_crc_ok <= 1'b1;
            @(posedge sys_clk);
            {index_pulse_input, id_valid} <= 2'b00;
            repeat (6) @(posedge sys_clk);
            mark_valid   <= 1'b1;
            mark_deleted <= mode[0];
            @(posedge sys_clk);
            mark_valid <= 1'b0;
            for (int i = 0; i < 128; i++) begin
               disk_byte_valid <= 1'b1;
               disk_byte       <= 8'(sec * 16 + i);
               @(posedge sys_clk);
               // Idle data line must not look like a held byte
               disk_byte_valid <= 1'b0;
               disk_byte       <= ~disk_byte;
               @(posedge sys_clk);
            end
            data_end    <= 1'b1;
            data_crc_ok <= !mode[1];
            @(posedge sys_clk);
            data_end <= 1'b0;
            sec = sec % 4 + 1;
            repeat (6) @(posedge sys_clk);
         end
      end
   end
endmodule

// >>> test/test_fdc_sector_read_engine.sv
// Self-checking bench for the read engine against the behavioural drive.
// Assumes the design package; the FIFO side stalls only in the stall test.
`timescale 1ns/1ps
module test_fdc_sector_read_engine;
   localparam logic [7:0] RD  = {3'h0, fdcsr_pkg::OP_READ};
   localparam logic [7:0] RDD = {3'h0, fdcsr_pkg::OP_READ_DEL};
   localparam logic [7:0] SKP = 8'h01 << fdcsr_pkg::SK_BIT;
   logic sys_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, implied_seek_en = 1'b0;
   logic terminal_count = 1'b0, fifo_ready = 1'b1;
   // Short unload so the closing idle wait sees the head drop
   logic [7:0] cmd_byte = 8'h00, settle_units = 8'h00, unload_units = 8'h02;
   logic [7:0] cyl = 8'h00, data_length_byte = 8'h01, r0 = 8'h01, seek_cyl, disk_byte, res_byte_q;
   logic [3:0] mode = 4'h0;
   logic [1:0] ds;
   logic       seek_done, seek_fail, index_pulse_input, id_valid, id_crc_ok, mark_valid;
   logic       mark_deleted, disk_byte_valid, data_end, data_crc_ok, fifo_over_q;
   logic       drive_busy_q, seek_req_q, head_load_q, exec_q, res_valid_q;
   fdcsr_pkg::fdcsr_chrn_s id_field;
   fdcsr_pkg::fdcsr_byte_s fifo_out_q;
   int         n_mismatch = 0, check_count = 0, n_bytes = 0, tc_at = 0;
   bit         over = 1'b0, hung = 1'b0;

   fdcsr_engine dut (.*);
   fdcsr_drive_model drive (.*);
   always #2.5 sys_clk = ~sys_clk;

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [7:0] exp_byte(int k);
      return 8'((r0 + k / data_length_byte) * 16 + k % data_length_byte);
   endfunction

   // ==========================================================
   // FIFO and seek monitor
   always @(posedge sys_clk) begin
      if (fifo_out_q.valid === 1'b1) begin
         check(16'(fifo_out_q.data), 16'(exp_byte(n_bytes)), "fifo byte");
         n_bytes = n_bytes + 1;
      end
      // count or stall after chosen byte
      terminal_count <= !over && fifo_out_q.valid === 1'b1 && n_bytes == tc_at;
      fifo_ready     <= !(over && tc_at > 0 && n_bytes >= tc_at);
      if (seek_req_q === 1'b1) check(16'(drive_busy_q), 16'h0001, "busy in seek");
   end

   // ==========================================================
   // One command: nine bytes in, seven result bytes out
   task automatic run(input logic [7:0] op, r, final_sector_number, input logic [3:0] m,
                      input logic [6:0] mask, input int tc, nsec, input string name);
      logic [7:0] cmd [9];
      logic [7:0] want [7];
      logic       bad;
      int         w;
      if (hung) return;
      bad = m[3] | m[2] | m[1];
      mode = m;
      cyl = 8'($urandom_range(70));
      data_length_byte = 8'($urandom_range(127, 1 + tc));
      ds = 2'($urandom);
      r0 = r;
      n_bytes = 0;
      tc_at = tc;
      implied_seek_en <= m[3];
      settle_units <= 8'($urandom_range(3));
      cmd = '{op, {6'h00, ds}, cyl, 8'h00, r, 8'h00, final_sector_number, 8'h1B, data_length_byte};
      want = '{{1'b0, bad, m[3], 3'h0, ds}, {2'h0, m[1], 2'h0, m[2], 2'h0},
               {1'b0, m[0] ^ (op[4:0] == fdcsr_pkg::OP_READ_DEL), 6'h00},
               m[3] ? cyl ^ 8'h0F : (tc > 0 ? cyl : cyl + 8'h01), 8'h00,
               tc > 0 ? r + 8'h01 : 8'h01, 8'h00};
      for (int i = 0; i < 9; i++) begin
         @(posedge sys_clk);
         cmd_valid <= 1'b1;
         cmd_byte  <= cmd[i];
      end
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      @(negedge sys_clk);
      check(16'(exec_q), 16'h0001, "execution start");
      check(16'(seek_req_q), 16'(m[3]), "seek request");
      w = 0;
      while (res_valid_q !== 1'b1 && w < 20000) begin
         @(negedge sys_clk);
         w++;
      end
      if (w == 20000) begin
         n_mismatch++;
         $display("wrong value at %0t: no result phase", $time);
         hung = 1'b1;
         return;
      end
      for (int k = 0; k < 7; k++) begin
         if (mask[k]) check(16'(res_byte_q), 16'(want[k]), "result");
         check(16'(res_valid_q), 16'h0001, "result strobe");
         @(negedge sys_clk);
      end
      if (tc > 0) check(16'(n_bytes > tc + 1), 16'h0000, "bytes past count");
      else check(16'(n_bytes), 16'(nsec) * 16'(data_length_byte), "byte count");
      if (!m[3]) check(16'(head_load_q), 16'h0001, "head kept loaded");
      check(16'(fifo_over_q), 16'(over), "implied count");
      check(16'(exec_q), 16'h0000, "execution end");
      $display("test %s done", name);
      repeat (3) @(posedge sys_clk);
   endtask

   initial begin
      int rr, ee;
      void'($urandom(32'h11ea));
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      run(RD, 8'h01, 8'h01, 4'h0, 7'h7F, 0, 1, "short sector");
      run(RD, 8'h02, 8'h04, 4'h0, 7'h7F, 0, 3, "multi sector");
      run(RD, 8'h01, 8'h03, 4'h0, 7'h7F, 1, 0, "terminal count");
      over = 1'b1;
      run(RD, 8'h02, 8'h04, 4'h0, 7'h7F, 1, 0, "fifo stall");
      over = 1'b0;
      run(RD, 8'h03, 8'h03, 4'h4, 7'h07, 0, 0, "no sector");
      run(RD, 8'h02, 8'h02, 4'h2, 7'h07, 0, 1, "data crc");
      run(RD, 8'h01, 8'h02, 4'h1, 7'h06, 0, 1, "deleted no skip");
      run(RD | SKP, 8'h01, 8'h01, 4'h1, 7'h04, 0, 0, "deleted skip");
      run(RDD, 8'h01, 8'h01, 4'h1, 7'h7F, 0, 1, "read deleted");
      run(RDD | SKP, 8'h02, 8'h02, 4'h0, 7'h04, 0, 0, "normal skip");
      run(RD, 8'h01, 8'h01, 4'h8, 7'h0B, 0, 0, "seek fail");
      for (int j = 0; j < 3; j++) begin
         rr = $urandom_range(4, 1);
         ee = $urandom_range(4, rr);
         run(RD, 8'(rr), 8'(ee), 4'h0, 7'h7F, 0, ee - rr + 1, "random span");
      end
      repeat (600) @(negedge sys_clk);
      check(16'(head_load_q), 16'h0000, "head unloaded");
      print_verdict();
   end
endmodule
